// ---- hw/cfgho_core_end.sv ----
`timescale 1ns/1ns
// Function
// [RULE_01] mask critical inputs while stage two loads
// [RULE_02] pass inputs through once stage two loaded
// [RULE_03] answer unhandled requests with UR before load
// [RULE_04] after load, flag loaded and forward requests
// [RULE_05] loaded flag: active high level
// [RULE_06] loaded low means isolation, bar accesses UR
// [RULE_07] host system governs loaded flag after load
// [RULE_08] raise cap request when host wants access
// [RULE_09] arbiter grants by raising grant
// [RULE_10] release request answered by dropping request
// [RULE_11] never drive config logic without grant; cfg_owned_out follows the request alone
// [RULE_12] other ports idle while core granted
// [RULE_13] core exclusive until first stage two load
// [RULE_14] single port: grant high, release low
// [RULE_15] synchronous active high interface reset out
// [RULE_16] interface clock is the core clock
// [RULE_17] link up high while link trained
// [RULE_18] bank outputs tristated until loaded
// [RULE_19] grant held until request drops

module cfgho_core_end #(
  parameter int unsigned TAG_W = cfgho_pkg::TAG_W
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // carrier toward the user end
  cfgho_if.core link,
  // stage two progress, host control of the loaded flag, link training and the host's wish for config access
  input wire logic stage2_done_in,
  input wire logic host_switch_in,
  input wire logic link_trained_in,
  input wire logic host_cfg_want_in,
  // host side config writes and tlp requests
  input wire logic cfg_wr_in,
  input wire logic [31:0] cfg_data_in,
  input wire logic tlp_req_in,
  input wire logic [TAG_W-1:0] tlp_tag_in,
  // masked inputs and answers toward the core
  output logic [cfgho_pkg::CRIT_W-1:0] crit_core_out,
  output logic cfg_wr_out,
  output logic [31:0] cfg_data_out,
  output logic cfg_owned_out,
  output logic ur_valid_out,
  output logic user_req_valid_out,
  output logic [TAG_W-1:0] ans_tag_out
);
  typedef struct packed {
    // reset stretch and interface reset
    logic [3:0] rst_cnt;
    logic iface_reset;
    // load tracking and link state
    logic ever_loaded;
    logic stage2;
    logic link_up;
    // arbitration and config path
    logic cap_req;
    logic cfg_wr;
    logic [31:0] cfg_data;
    // tlp answer path
    logic ur_valid;
    logic user_valid;
    logic [TAG_W-1:0] tag;
  } cfgho_core_s;
  cfgho_core_s st_ff;
  cfgho_core_s nxt_st;

  // request answer decode, used for the answer strobe pair
  function automatic cfgho_pkg::cfgho_ans_e ans_kind(input logic req, input logic loaded);
    if (!req) begin
      ans_kind = cfgho_pkg::CFGHO_ANS_NONE;
    end else if (loaded) begin
      ans_kind = cfgho_pkg::CFGHO_ANS_USER;
    end else begin
      ans_kind = cfgho_pkg::CFGHO_ANS_UR;
    end
  endfunction : ans_kind

  // next value of the reset stretch counter, parks at zero
  function automatic logic [3:0] count_down(input logic [3:0] cnt);
    if (cnt == 4'h0) begin
      count_down = 4'h0;
    end else begin
      count_down = cnt - 4'h1;
    end
  endfunction : count_down

  // a release ask only counts while the grant still stands
  function automatic logic release_asked(input logic rel, input logic gnt);
    release_asked = rel && gnt;
  endfunction : release_asked

  // config traffic passes only while request and grant both stand
  function automatic logic owns_logic(input logic req, input logic gnt);
    owns_logic = req && gnt;
  endfunction : owns_logic

  // answer kind of this cycle's request
  cfgho_pkg::cfgho_ans_e ans;
  // release ask seen this cycle, feeds the request path
  logic rel_now;

  // next state of the whole core end
  always_comb begin
    nxt_st = st_ff;
    ans = ans_kind(tlp_req_in, st_ff.stage2);
    rel_now = release_asked(link.cap_rel, link.cap_gnt); // [RULE_10]

    // reset stretch; output deasserts only after the count runs out
    nxt_st.rst_cnt = count_down(st_ff.rst_cnt);
    nxt_st.iface_reset = (st_ff.rst_cnt != 4'h0); // [RULE_15]

    // first load latches loaded; afterwards the host decides
    if (!st_ff.ever_loaded) begin
      nxt_st.stage2 = stage2_done_in; // [RULE_05]
      nxt_st.ever_loaded = stage2_done_in;
    end else begin
      nxt_st.stage2 = host_switch_in; // [RULE_07]
    end

    // no link flag while the core is still held in reset
    nxt_st.link_up = link_trained_in && !st_ff.iface_reset; // [RULE_17]

    // request follows host wish; a release ask drops it once granted
    nxt_st.cap_req = host_cfg_want_in && !rel_now; // [RULE_08] [RULE_10]

    // config writes only pass while request and grant both stand
    nxt_st.cfg_wr = cfg_wr_in && owns_logic(st_ff.cap_req, link.cap_gnt); // [RULE_11]
    if (cfg_wr_in) begin
      nxt_st.cfg_data = cfg_data_in;
    end

    // isolated core answers UR itself, else user gets it
    nxt_st.ur_valid = 1'b0;
    nxt_st.user_valid = 1'b0;
    case (ans)
      cfgho_pkg::CFGHO_ANS_UR: begin
        nxt_st.ur_valid = 1'b1; // [RULE_03] [RULE_06]
      end
      cfgho_pkg::CFGHO_ANS_USER: begin
        nxt_st.user_valid = 1'b1; // [RULE_04]
      end
      default: begin
        // no request this cycle, both strobes stay low
      end
    endcase

    // tag of the last request stays until the next one
    if (tlp_req_in) begin
      nxt_st.tag = tlp_tag_in;
    end

    // no strobe reaches the config logic or the answer path in reset; data and tag still load
    if (st_ff.iface_reset) begin
      nxt_st.cap_req = 1'b0;
      nxt_st.cfg_wr = 1'b0;
      nxt_st.ur_valid = 1'b0;
      nxt_st.user_valid = 1'b0;
    end
  end

  // one register for the whole state; reset is asynchronous
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // each field to its own level; the interface reset starts high
      st_ff.rst_cnt <= cfgho_pkg::CORE_RST_CYC;
      st_ff.iface_reset <= 1'b1;
      st_ff.ever_loaded <= 1'b0;
      st_ff.stage2 <= cfgho_pkg::RST_STAGE2;
      st_ff.link_up <= 1'b0;
      st_ff.cap_req <= cfgho_pkg::RST_REQ;
      st_ff.cfg_wr <= 1'b0;
      st_ff.cfg_data <= '0;
      st_ff.ur_valid <= 1'b0;
      st_ff.user_valid <= 1'b0;
      st_ff.tag <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // critical inputs from the user side, masked before load
  cfgho_crit_mux #(
    .WIDTH(cfgho_pkg::CRIT_W)
  ) i_cfgho_crit_mux (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .sel_user_in(st_ff.stage2), // [RULE_01] [RULE_02]
    .user_in(link.crit),
    .muxed_out(crit_core_out)
  );

  // the interface clock is the core clock itself, no divider
  assign link.iface_clk = core_clk_in; // [RULE_16]
  assign link.iface_reset = st_ff.iface_reset;
  assign link.link_up = st_ff.link_up;
  assign link.stage2_loaded = st_ff.stage2;
  assign link.cap_req = st_ff.cap_req;

  // core side outputs, each straight from its flop
  assign cfg_wr_out = st_ff.cfg_wr;
  assign cfg_data_out = st_ff.cfg_data;
  assign cfg_owned_out = st_ff.cap_req;
  assign ur_valid_out = st_ff.ur_valid;
  assign user_req_valid_out = st_ff.user_valid;
  assign ans_tag_out = st_ff.tag;
endmodule : cfgho_core_end

// ---- hw/cfgho_crit_mux.sv ----
`timescale 1ns/1ns
// holds critical inputs deasserted until stage two is in place
module cfgho_crit_mux #(
  parameter int unsigned WIDTH = cfgho_pkg::CRIT_W
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic sel_user_in,
  input wire logic [WIDTH-1:0] user_in,
  output logic [WIDTH-1:0] muxed_out
);
  typedef struct packed {
    logic [WIDTH-1:0] val;
  } cfgho_mux_s;
  cfgho_mux_s st_ff;
  cfgho_mux_s nxt_st;

  // registered so glitches from unloaded logic never reach the core
  always_comb begin
    nxt_st = st_ff;
    nxt_st.val = sel_user_in ? user_in : '0; // [RULE_01] [RULE_02]
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign muxed_out = st_ff.val;
endmodule : cfgho_crit_mux

// ---- hw/cfgho_user_end.sv ----
`timescale 1ns/1ns
// user side arbiter between core config port and internal_cfg_port
module cfgho_user_end (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  cfgho_if.user link,
  input wire logic single_port_in,
  input wire logic other_want_in,
  input wire logic [cfgho_pkg::CRIT_W-1:0] crit_in,
  output logic other_gnt_out,
  output logic out_en_out,
  output logic loaded_out,
  output logic link_up_out
);
  typedef enum logic [1:0] {
    CFGHO_IDLE,
    CFGHO_CORE,
    CFGHO_OTHER
  } cfgho_arb_e;
  typedef struct packed {
    cfgho_arb_e arb;
    logic gnt;
    logic rel;
    logic other_gnt;
    logic [7:0] hold;
    logic seen_load;
    logic out_en;
    logic loaded;
    logic link_up;
    logic [cfgho_pkg::CRIT_W-1:0] crit;
  } cfgho_user_s;
  cfgho_user_s st_ff;
  cfgho_user_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.seen_load = st_ff.seen_load || link.stage2_loaded;
    nxt_st.out_en = link.stage2_loaded; // [RULE_18]
    nxt_st.loaded = link.stage2_loaded;
    nxt_st.link_up = link.link_up;
    nxt_st.crit = crit_in;
    case (st_ff.arb)
      CFGHO_IDLE: begin
        nxt_st.gnt = 1'b0;
        nxt_st.rel = 1'b0;
        nxt_st.hold = 8'h00;
        // core first; others only after first load
        if (link.cap_req) begin
          nxt_st.arb = CFGHO_CORE;
          nxt_st.gnt = 1'b1; // [RULE_09]
        end else if (other_want_in && st_ff.seen_load) begin // [RULE_13]
          nxt_st.arb = CFGHO_OTHER;
          nxt_st.other_gnt = 1'b1;
        end
      end
      CFGHO_CORE: begin
        nxt_st.other_gnt = 1'b0; // [RULE_12]
        if (!link.cap_req) begin
          nxt_st.arb = CFGHO_IDLE;
          nxt_st.gnt = 1'b0; // [RULE_19]
          nxt_st.rel = 1'b0;
        end else if (other_want_in && st_ff.seen_load) begin
          // ask release only after a fair holding time
          if (st_ff.hold == cfgho_pkg::REL_HOLD_CYC) begin
            nxt_st.rel = 1'b1; // [RULE_10]
          end else begin
            nxt_st.hold = st_ff.hold + 8'h01;
          end
        end
      end
      CFGHO_OTHER: begin
        if (!other_want_in) begin
          nxt_st.arb = CFGHO_IDLE;
          nxt_st.other_gnt = 1'b0;
        end
      end
      default: begin
        nxt_st.arb = CFGHO_IDLE;
      end
    endcase
    // lone config port: grant tied high, release tied low
    if (single_port_in) begin
      nxt_st.arb = CFGHO_IDLE;
      nxt_st.gnt = 1'b1; // [RULE_14]
      nxt_st.rel = 1'b0;
      nxt_st.other_gnt = 1'b0;
    end
    if (link.iface_reset) begin
      nxt_st.arb = CFGHO_IDLE;
      nxt_st.gnt = single_port_in;
      nxt_st.rel = 1'b0;
      nxt_st.other_gnt = 1'b0;
    end
  end

  // logic talking to the core runs on the core's own clock
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin // [RULE_16]
    if (!reset_n_in) begin
      st_ff <= '0;
      st_ff.arb <= CFGHO_IDLE;
      st_ff.gnt <= cfgho_pkg::RST_GNT;
      st_ff.rel <= cfgho_pkg::RST_REL;
      st_ff.crit <= cfgho_pkg::RST_CRIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.cap_gnt = st_ff.gnt;
  assign link.cap_rel = st_ff.rel;
  assign link.crit = st_ff.crit;
  assign other_gnt_out = st_ff.other_gnt;
  assign out_en_out = st_ff.out_en;
  assign loaded_out = st_ff.loaded;
  assign link_up_out = st_ff.link_up;
endmodule : cfgho_user_end

// ---- shared/cfgho_if.sv ----
`timescale 1ns/1ns
interface cfgho_if;
  logic iface_clk;
  logic iface_reset;
  logic link_up;
  logic stage2_loaded;
  logic cap_req;
  logic cap_gnt;
  logic cap_rel;
  logic [cfgho_pkg::CRIT_W-1:0] crit;
  modport core (
    output iface_clk,
    output iface_reset,
    output link_up,
    output stage2_loaded,
    output cap_req,
    input cap_gnt,
    input cap_rel,
    input crit
  );
  modport user (
    input iface_clk,
    input iface_reset,
    input link_up,
    input stage2_loaded,
    input cap_req,
    output cap_gnt,
    output cap_rel,
    output crit
  );
endinterface : cfgho_if

// ---- shared/cfgho_pkg.sv ----
package cfgho_pkg;
  // widths of the masked critical inputs and of the request tag
  localparam int unsigned CRIT_W = 4;
  localparam int unsigned TAG_W = 8;
  // levels after reset
  localparam logic RST_STAGE2 = 1'b0;
  localparam logic RST_REQ = 1'b0;
  localparam logic RST_GNT = 1'b0;
  localparam logic RST_REL = 1'b0;
  localparam logic [3:0] RST_CRIT = 4'h0;
  // start of the reset stretch count; the core stays in reset for one cycle more than this after reset_n_in rises
  localparam logic [3:0] CORE_RST_CYC = 4'h4;
  // cycles the user arbiter waits before asking for release
  localparam logic [7:0] REL_HOLD_CYC = 8'h10;
  // answer kinds of a tlp request
  typedef enum logic [1:0] {
    CFGHO_ANS_NONE,
    CFGHO_ANS_UR,
    CFGHO_ANS_USER
  } cfgho_ans_e;
endpackage : cfgho_pkg

// ---- tb/cfgho_chk_sva.sv ----
`timescale 1ns/1ns
// watches the cap handshake between both ends
module cfgho_chk_sva (
  input wire logic iface_clk,
  input wire logic iface_reset,
  input wire logic stage2_loaded,
  input wire logic cap_req,
  input wire logic cap_gnt,
  input wire logic cap_rel,
  input wire logic single_port
);
  logic seen_ff;
  logic [7:0] held_ff;
  // first load seen, and cycles of unbroken grant (saturates)
  always_ff @(posedge iface_clk) begin
    if (iface_reset) begin
      seen_ff <= 1'b0;
      held_ff <= 8'h00;
    end else begin
      seen_ff <= seen_ff | stage2_loaded;
      held_ff <= !cap_gnt ? 8'h00 : (held_ff == 8'hFF ? held_ff : held_ff + 8'h01);
    end
  end
  default clocking @(posedge iface_clk); endclocking
  default disable iff (iface_reset);
  // release asked while the core owns the logic
  sequence s_rel_ask;
    cap_rel && cap_gnt && cap_req;
  endsequence
  // core lets go, then the arbiter clears grant and release
  sequence s_handback;
    ##1 !cap_req ##1 (!cap_gnt && !cap_rel);
  endsequence
  property p_rel_drops_req;
    s_rel_ask |-> s_handback;
  endproperty
  a_rel_drops_req: assert property (p_rel_drops_req) else $error("request kept after release");
  property p_req_gets_gnt;
    $rose(cap_req) |=> cap_gnt;
  endproperty
  a_req_gets_gnt: assert property (p_req_gets_gnt) else $error("request not granted");
  // a lone port has its grant tied high, so grant order only holds when shared
  property p_gnt_needs_req;
    $rose(cap_gnt) && !single_port |-> $past(cap_req);
  endproperty
  a_gnt_needs_req: assert property (p_gnt_needs_req) else $error("grant without request");
  property p_gnt_held;
    cap_req && cap_gnt |=> cap_gnt;
  endproperty
  a_gnt_held: assert property (p_gnt_held) else $error("grant dropped under request");
  property p_gnt_released;
    $fell(cap_req) && !single_port |=> !cap_gnt && !cap_rel;
  endproperty
  a_gnt_released: assert property (p_gnt_released) else $error("grant kept after request");
  property p_rel_in_grant;
    cap_rel |-> cap_gnt;
  endproperty
  a_rel_in_grant: assert property (p_rel_in_grant) else $error("release without grant");
  property p_excl;
    cap_rel |-> seen_ff || stage2_loaded;
  endproperty
  a_excl: assert property (p_excl) else $error("release before first load");
  property p_rel_hold;
    $rose(cap_rel) |-> held_ff >= 8'h0F;
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("release too early in grant");
endmodule : cfgho_chk_sva

// ---- tb/config_access_handoff_bench.sv ----
`timescale 1ns/1ns
module config_access_handoff_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sgl = 1'b0;
  logic done = 1'b0, hsw = 1'b1, trn = 1'b0, want = 1'b0, wr = 1'b0, tlp = 1'b0, oth = 1'b0;
  logic [31:0] dat = 32'h0;
  logic [7:0] tag = 8'h0;
  logic [3:0] cri = 4'h0;
  logic [3:0] cri_o;
  logic [31:0] dat_o;
  logic [7:0] tag_o;
  logic wr_o, own, ur, usr, ogn, oen, ldd, lup;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  cfgho_if lnk ();
  cfgho_core_end i_cfgho_core_end (.core_clk_in(clk), .reset_n_in(rst_n), .link(lnk),
    .stage2_done_in(done), .host_switch_in(hsw), .link_trained_in(trn), .host_cfg_want_in(want),
    .cfg_wr_in(wr), .cfg_data_in(dat), .tlp_req_in(tlp), .tlp_tag_in(tag), .crit_core_out(cri_o),
    .cfg_wr_out(wr_o), .cfg_data_out(dat_o), .cfg_owned_out(own), .ur_valid_out(ur),
    .user_req_valid_out(usr), .ans_tag_out(tag_o));
  cfgho_user_end i_cfgho_user_end (.core_clk_in(clk), .reset_n_in(rst_n), .link(lnk),
    .single_port_in(sgl), .other_want_in(oth), .crit_in(cri), .other_gnt_out(ogn),
    .out_en_out(oen), .loaded_out(ldd), .link_up_out(lup));
  cfgho_chk_sva i_cfgho_chk_sva (.iface_clk(lnk.iface_clk), .iface_reset(lnk.iface_reset),
    .stage2_loaded(lnk.stage2_loaded), .cap_req(lnk.cap_req), .cap_gnt(lnk.cap_gnt),
    .cap_rel(lnk.cap_rel), .single_port(sgl));
  // 50 ns period
  always #25 clk = ~clk;
  // inputs move 5 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // one request pulse, answered as ur or handed to the user
  task automatic t_tlp(input logic [7:0] t, input logic exp_ur);
    tlp = 1'b1;
    tag = t;
    step(1);
    tlp = 1'b0;
    chk(ur, exp_ur);
    chk(usr, !exp_ur);
    chk(tag_o, t);
  endtask : t_tlp
  task automatic t_reset();
    chk(lnk.iface_reset, 1'b1);
    step(6);
    chk(lnk.iface_reset, 1'b0);
    chk(lnk.stage2_loaded, 1'b0);
    chk(lnk.iface_clk === clk, 1'b1);
  endtask : t_reset
  task automatic t_isolated();
    cri = 4'hA;
    trn = 1'b1;
    step(4);
    chk(cri_o, 4'h0);
    chk(oen, 1'b0);
    chk(lup, 1'b1);
    t_tlp(8'h3C, 1'b1);
  endtask : t_isolated
  // write refused until the grant lands; no release before load
  task automatic t_access();
    want = 1'b1;
    oth = 1'b1;
    step(1);
    chk(lnk.cap_req, 1'b1);
    chk(own, 1'b1);
    wr = 1'b1;
    dat = 32'h5A5A0F0F;
    step(1);
    chk(wr_o, 1'b0);
    chk(lnk.cap_gnt, 1'b1);
    dat = 32'hC3A51E2D;
    step(1);
    wr = 1'b0;
    chk(wr_o, 1'b1);
    chk(dat_o, 32'hC3A51E2D);
    step(30);
    chk(lnk.cap_rel, 1'b0);
    chk(ogn, 1'b0);
    oth = 1'b0;
  endtask : t_access
  task automatic t_load();
    done = 1'b1;
    step(1);
    chk(lnk.stage2_loaded, 1'b1);
    step(3);
    chk(cri_o, 4'hA);
    chk(oen, 1'b1);
    chk(ldd, 1'b1);
    t_tlp(8'hC5, 1'b0);
  endtask : t_load
  // other port asks; core must hand the logic back
  task automatic t_release();
    int n;
    oth = 1'b1;
    for (n = 0; n < 40 && lnk.cap_rel !== 1'b1; n++) step(1);
    chk(lnk.cap_rel, 1'b1);
    want = 1'b0;
    step(1);
    chk(lnk.cap_req, 1'b0);
    chk(own, 1'b0);
    step(1);
    chk(lnk.cap_gnt, 1'b0);
    step(2);
    chk(ogn, 1'b1);
    hsw = 1'b0;
    step(1);
    chk(lnk.stage2_loaded, 1'b0);
    t_tlp(8'h81, 1'b1);
  endtask : t_release
  // reset in mid-run into lone-port mode: grant tied high, release low
  task automatic t_single();
    rst_n = 1'b0;
    sgl = 1'b1;
    hsw = 1'b1;
    want = 1'b1;
    oth = 1'b0;
    step(2);
    chk(lnk.iface_reset, 1'b1);
    chk(lnk.cap_req, 1'b0);
    rst_n = 1'b1;
    step(1);
    chk(lnk.cap_gnt, 1'b1);
    chk(lnk.stage2_loaded, 1'b1);
    step(5);
    chk(lnk.iface_reset, 1'b0);
    chk(lnk.cap_req, 1'b1);
    chk(own, 1'b1);
    wr = 1'b1;
    dat = 32'h0F1E2D3C;
    step(1);
    wr = 1'b0;
    want = 1'b0;
    chk(wr_o, 1'b1);
    chk(dat_o, 32'h0F1E2D3C);
    step(2);
    chk(lnk.cap_req, 1'b0);
    chk(lnk.cap_gnt, 1'b1);
    chk(lnk.cap_rel, 1'b0);
    chk(ogn, 1'b0);
  endtask : t_single
  // hang guard, far above the roughly one hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    step(10);
    rst_n = 1'b1;
    t_reset();
    t_isolated();
    t_access();
    t_load();
    t_release();
    t_single();
    tally_and_finish();
  end
endmodule : config_access_handoff_bench
